/* common/irq_sync_if.sv */
`timescale 1ns/10ps
interface irq_sync_if;
    logic [7:0] lineActive;  // synchronised, active high irq line levels
    modport producer (output lineActive);
    modport consumer (input lineActive);
endinterface

/* common/trap_mon_map.svh */
`ifndef TRAP_MON_MAP_SVH
`define TRAP_MON_MAP_SVH

// register offsets inside the power management i/o window
`define OFS_MON_TRAP 8'h40
`define OFS_DEV_ACT  8'h44
`define OFS_DEV_TRAP 8'h48
`define OFS_ADDR_CAP 8'h4C
`define OFS_CYC_CAP  8'h4E

// reset value shared by every register
`define RST_REG16 16'h0000
`define RST_REG8  8'h00

// field positions of the monitor register
`define MON_STS_LSB 12
`define MON_STS_MSB 15
`define MON_EN_LSB  8
`define MON_EN_MSB  11

// implemented bits of the activity and trap registers, and the ide drive range bits
`define ACT_VALID_MASK  16'h3FEF
`define TRAP_VALID_MASK 16'h3C2F
`define IDE_RANGE_MASK  16'h000F

// irq pair activity bits sit at 9:6
`define ACT_IRQ_LSB 6
`define ACT_IRQ_MSB 9

// synchroniser depth for pin inputs
`define SYNC_STAGES 3

`endif

/* common/trap_mon_pkg.sv */
package trap_mon_pkg;
    typedef logic [15:0] word_t;    // one register word
    typedef logic [7:0]  offset_t;  // register offset
    typedef logic [3:0]  nibble_t;  // byte enables, cycle type, monitor group
endpackage

/* testbench/io_cycle_host.sv */
`timescale 1ns/10ps
module io_cycle_host
    import trap_mon_pkg::*;
(
    input  wire logic clk,
    output logic      ioCycValid,
    output word_t     ioAddr,
    output nibble_t   ioByteEn,
    output nibble_t   ioCycType,
    output word_t     rangeHit,
    output nibble_t   monitorHit
);
    // idle bus: valid low, qualifiers hold junk so stale values are never trusted
    initial
    begin
        ioCycValid = 1'b0;
        ioAddr     = 16'hA5A5;
        ioByteEn   = 4'h0;
        ioCycType  = 4'h0;
        rangeHit   = 16'h0000;
        monitorHit = 4'h0;
    end

    // one decoded io cycle, launched just after an edge and held through one edge
    task automatic issue(input word_t addr, input nibble_t be, input nibble_t typ,
                         input word_t hit, input nibble_t mon);
        ioCycValid = 1'b1;
        ioAddr     = addr;
        ioByteEn   = be;
        ioCycType  = typ;
        rangeHit   = hit;
        monitorHit = mon;
        @(posedge clk);
        #1;
        ioCycValid = 1'b0;
        ioAddr     = ~addr;
        ioByteEn   = ~be;
        rangeHit   = 16'h0000;
        monitorHit = 4'h0;
    endtask
endmodule

/* testbench/testbench.sv */
`timescale 1ns/10ps
module testbench
    import trap_mon_pkg::*;
;
    logic       clk;       // 100 ns core clock
    logic       rstn;      // active low reset
    offset_t    regOffset; // register port
    logic       regWrite;
    logic       regRead;
    word_t      regWdata;
    word_t      regRdata;
    logic       ioCycValid;
    word_t      ioAddr;
    nibble_t    ioByteEn;
    nibble_t    ioCycType;
    nibble_t    monitorHit;
    word_t      rangeHit;
    logic [7:0] pciIrqN;   // irq pins, active low
    logic       gblEn;     // global interrupt enable
    logic       smi;
    logic       summary;
    logic       lpcBlk;
    logic       ideBlk;
    int         failures;
    int         numChecks;
    offset_t    ofsList [6] = '{8'h40, 8'h44, 8'h48, 8'h4C, 8'h4E, 8'h50};

    device_activity_trap_monitor u_device_activity_trap_monitor (
        .clk(clk), .rstn(rstn), .regOffset(regOffset), .regWrite(regWrite), .regRead(regRead),
        .regWdata(regWdata), .regRdata(regRdata), .ioCycValid(ioCycValid), .ioAddr(ioAddr),
        .ioByteEn(ioByteEn), .ioCycType(ioCycType), .monitorHit(monitorHit), .rangeHit(rangeHit),
        .pciIrqN(pciIrqN), .globalMgmtIrqEnable(gblEn), .systemMgmtInterrupt(smi),
        .monitorSummaryStatus(summary), .lpcForwardBlock(lpcBlk), .ideForwardBlock(ideBlk));

    io_cycle_host u_io_cycle_host (
        .clk(clk), .ioCycValid(ioCycValid), .ioAddr(ioAddr), .ioByteEn(ioByteEn),
        .ioCycType(ioCycType), .rangeHit(rangeHit), .monitorHit(monitorHit));

    // free running clock
    always #50 clk = ~clk;

    // one comparison, counted
    task automatic chk(input word_t got, input word_t exp);
        numChecks++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // one write strobe, data scrambled after so nothing leans on it
    task automatic wr(input offset_t ofs, input word_t dat);
        regWrite  = 1'b1;
        regOffset = ofs;
        regWdata  = dat;
        @(posedge clk);
        #1;
        regWrite = 1'b0;
        regWdata = ~dat;
    endtask

    // one read strobe; data sampled a full cycle later where it is settled
    task automatic rd(input offset_t ofs, input word_t exp);
        regRead   = 1'b1;
        regOffset = ofs;
        @(posedge clk);
        #1;
        regRead = 1'b0;
        @(posedge clk);
        #1;
        chk(regRdata, exp);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // single place where the run ends
    task automatic complete_run();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // watchdog: the sequence needs a few hundred cycles at most
    initial
    begin
        #200000;
        failures++;
        complete_run();
    end

    // main sequence
    initial
    begin
        clk       = 1'b0;
        rstn      = 1'b0;
        regOffset = 8'h00;
        regWrite  = 1'b0;
        regRead   = 1'b0;
        regWdata  = 16'h0000;
        // asynchronous irq sources stay quiet while the captures are checked
        pciIrqN   = 8'hFF;
        gblEn     = 1'b0;
        failures  = 0;
        numChecks = 0;
        idle(3);
        rstn = 1'b1;
        foreach (ofsList[i]) rd(ofsList[i], 16'h0000);
        wr(8'h48, 16'hFFFF);
        rd(8'h48, 16'h3C2F);
        wr(8'h40, 16'hFFFF);
        rd(8'h40, 16'h0F00);
        wr(8'h4C, 16'h1234);
        rd(8'h4C, 16'h0000);
        // trap while the global enable is off: summary only
        u_io_cycle_host.issue(16'h0388, 4'h1, 4'h3, 16'h2000, 4'h0);
        idle(2);
        chk(word_t'(smi), 16'h0000);
        chk(word_t'(summary), 16'h0001);
        rd(8'h44, 16'h2000);
        wr(8'h44, 16'h2000);
        rd(8'h44, 16'h0000);
        gblEn = 1'b1;
        u_io_cycle_host.issue(16'h0060, 4'h3, 4'h2, 16'h1000, 4'h0);
        chk(word_t'({lpcBlk, ideBlk}), 16'h0002);
        idle(1);
        chk(word_t'({smi, lpcBlk}), 16'h0002);
        rd(8'h4C, 16'h0060);
        rd(8'h4E, 16'h0032);
        rd(8'h44, 16'h1000);
        wr(8'h44, 16'h1000);
        idle(3);
        chk(word_t'(smi), 16'h0000);
        chk(word_t'(summary), 16'h0000);
        // drive range goes to the other forward path
        u_io_cycle_host.issue(16'h01F0, 4'hE, 4'h3, 16'h0001, 4'h0);
        chk(word_t'({lpcBlk, ideBlk}), 16'h0001);
        idle(1);
        rd(8'h4C, 16'h01F0);
        // a drive access and a clear of its bit in one cycle: the access must survive
        fork
            u_io_cycle_host.issue(16'h01F0, 4'hE, 4'h3, 16'h0001, 4'h0);
            wr(8'h44, 16'h0001);
        join
        rd(8'h44, 16'h0001);
        wr(8'h44, 16'h0001);
        u_io_cycle_host.issue(16'h0300, 4'h0, 4'h2, 16'h0000, 4'h1);
        idle(1);
        chk(word_t'(smi), 16'h0001);
        rd(8'h40, 16'h1F00);
        wr(8'h40, 16'h1E00);
        rd(8'h40, 16'h0E00);
        u_io_cycle_host.issue(16'h0300, 4'h0, 4'h2, 16'h0000, 4'h1);
        rd(8'h40, 16'h0E00);
        // lines F and H low mark the B-or-F and D-or-H pairs
        pciIrqN = 8'h5F;
        idle(6);
        rd(8'h44, 16'h0280);
        pciIrqN = 8'hFF;
        idle(5);
        wr(8'h44, 16'h0280);
        rd(8'h44, 16'h0000);
        complete_run();
    end
endmodule

/* verilog/device_activity_trap_monitor.sv */
// Function
// - monitor status 15:12 set by trapped monitor access
// - monitor enables 11:8 allow monitor interrupt
// - status bits clear on write one only
// - io range access sets its activity bit
// - irq pair activity sets bits 9 to 6
// - trap enable plus status raises interrupt
// - trapped ranges are not forwarded onward
// - address capture latched on interrupt rise
// - byte enables and type latched on rise
// - summary is OR of enabled status bits
// - interrupt only while global enable set
`timescale 1ns/10ps
`include "trap_mon_map.svh"
module device_activity_trap_monitor
    import trap_mon_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rstn,
    input  wire offset_t     regOffset,
    input  wire logic        regWrite,
    input  wire logic        regRead,
    input  wire word_t       regWdata,
    output word_t            regRdata,
    input  wire logic        ioCycValid,
    input  wire word_t       ioAddr,
    input  wire nibble_t     ioByteEn,
    input  wire nibble_t     ioCycType,
    input  wire nibble_t     monitorHit,
    input  wire word_t       rangeHit,
    input  wire logic [7:0]  pciIrqN,
    input  wire logic        globalMgmtIrqEnable,
    output logic             systemMgmtInterrupt,
    output logic             monitorSummaryStatus,
    output logic             lpcForwardBlock,
    output logic             ideForwardBlock
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    irq_sync_if irqIf ();  // synchronised irq line levels

    // pin synchroniser for the pci interrupt lines
    irq_line_sync #(.LINES(8)) u_irq_sync
    (
        .clk     (clk),
        .rstn    (rstn),
        .pciIrqN (pciIrqN),
        .sync    (irqIf.producer)
    );

    nibble_t    monSts_q, monSts_d;    // monitor 4..7 trap status
    nibble_t    monEn_q, monEn_d;      // monitor 4..7 trap enables
    word_t      actSts_q, actSts_d;    // device activity status
    word_t      trapEn_q, trapEn_d;    // device trap enables
    word_t      lastAddr_q, lastAddr_d; // running copy of the latest io cycle
    nibble_t    lastBe_q, lastBe_d;
    nibble_t    lastType_q, lastType_d;
    word_t      addrCap_q, addrCap_d;  // address capture register
    logic [7:0] cycCap_q, cycCap_d;    // cycle capture register
    logic       smi_q, smi_d;          // interrupt output, active high
    logic       summary_q, summary_d;  // monitor summary status
    logic       lpcBlk_q, lpcBlk_d;    // forward block toward lpc
    logic       ideBlk_q, ideBlk_d;    // forward block toward ide
    word_t      rdata_q, rdata_d;      // registered read data
    logic       wrMon, wrAct, wrTrap;  // register write strobes
    nibble_t    monSet;                // monitor status set terms
    word_t      actSet;                // activity set terms
    word_t      trapHit;               // current cycle hits a trapped range
    logic [3:0] irqPair;               // paired irq activity

    // next-state logic for all register and output state
    always_comb
    begin
        wrMon  = regWrite && (regOffset == `OFS_MON_TRAP);
        wrAct  = regWrite && (regOffset == `OFS_DEV_ACT);
        wrTrap = regWrite && (regOffset == `OFS_DEV_TRAP);

        // monitor status only records accesses that actually trap
        monSet = ioCycValid ? (monitorHit & monEn_q) : 4'h0;
        monEn_d = wrMon ? regWdata[`MON_EN_MSB:`MON_EN_LSB] : monEn_q;
        // clear first, then or in the set so a same-cycle event survives
        monSts_d = (monSts_q & ~(wrMon ? regWdata[`MON_STS_MSB:`MON_STS_LSB] : 4'h0)) | monSet;

        // pair a..d with e..h
        irqPair = irqIf.lineActive[3:0] | irqIf.lineActive[7:4];
        // hit decode is done outside; ranges arrive one bit per activity position
        actSet = ioCycValid ? rangeHit : 16'h0000;
        actSet[`ACT_IRQ_MSB:`ACT_IRQ_LSB] = irqPair;
        actSts_d = ((actSts_q & ~(wrAct ? regWdata : 16'h0000)) | actSet) & `ACT_VALID_MASK;

        // reserved trap enable bits never store a one
        trapEn_d = wrTrap ? (regWdata & `TRAP_VALID_MASK) : trapEn_q;

        // forwarding block follows the trapped cycle by one clock
        trapHit  = ioCycValid ? (rangeHit & trapEn_q) : 16'h0000;
        lpcBlk_d = |(trapHit & ~`IDE_RANGE_MASK);
        ideBlk_d = |(trapHit & `IDE_RANGE_MASK);

        // summary ignores the global enable; only the pin is gated
        summary_d = (|(monSts_q & monEn_q)) | (|(actSts_q & trapEn_q));
        smi_d     = globalMgmtIrqEnable && summary_d;

        // track the most recent io cycle, whatever bus it ran on
        lastAddr_d = lastAddr_q;
        lastBe_d   = lastBe_q;
        lastType_d = lastType_q;
        if (ioCycValid)
        begin
            lastAddr_d = ioAddr;
            lastBe_d   = ioByteEn;
            lastType_d = ioCycType;
        end

        // freeze the tracked cycle on the interrupt's rising edge
        addrCap_d = addrCap_q;
        cycCap_d  = cycCap_q;
        if (smi_d && !smi_q)
        begin
            addrCap_d = lastAddr_q;
            cycCap_d  = {lastBe_q, lastType_q};
        end

        // read mux; unmapped offsets and reserved bits return zero
        rdata_d = rdata_q;
        if (regRead)
        begin
            case (regOffset)
                `OFS_MON_TRAP: rdata_d = {monSts_q, monEn_q, 8'h00};
                `OFS_DEV_ACT:  rdata_d = actSts_q;
                `OFS_DEV_TRAP: rdata_d = trapEn_q;
                `OFS_ADDR_CAP: rdata_d = addrCap_q;
                `OFS_CYC_CAP:  rdata_d = {8'h00, cycCap_q};
                default:       rdata_d = 16'h0000;
            endcase
        end
    end

    // register every piece of state
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            monSts_q   <= 4'h0;
            monEn_q    <= 4'h0;
            actSts_q   <= `RST_REG16;
            trapEn_q   <= `RST_REG16;
            lastAddr_q <= `RST_REG16;
            lastBe_q   <= 4'h0;
            lastType_q <= 4'h0;
            addrCap_q  <= `RST_REG16;
            cycCap_q   <= `RST_REG8;
            smi_q      <= 1'b0;
            summary_q  <= 1'b0;
            lpcBlk_q   <= 1'b0;
            ideBlk_q   <= 1'b0;
            rdata_q    <= `RST_REG16;
        end
        else
        begin
            monSts_q   <= monSts_d;
            monEn_q    <= monEn_d;
            actSts_q   <= actSts_d;
            trapEn_q   <= trapEn_d;
            lastAddr_q <= lastAddr_d;
            lastBe_q   <= lastBe_d;
            lastType_q <= lastType_d;
            addrCap_q  <= addrCap_d;
            cycCap_q   <= cycCap_d;
            smi_q      <= smi_d;
            summary_q  <= summary_d;
            lpcBlk_q   <= lpcBlk_d;
            ideBlk_q   <= ideBlk_d;
            rdata_q    <= rdata_d;
        end
    end

    assign regRdata             = rdata_q;
    assign systemMgmtInterrupt  = smi_q;
    assign monitorSummaryStatus = summary_q;
    assign lpcForwardBlock      = lpcBlk_q;
    assign ideForwardBlock      = ideBlk_q;

    // checks next to the logic they guard
    a_mon_set: assert property (ioCycValid && monitorHit[0] && monEn_q[0] |=> monSts_q[0])
        else $error("monitor status not set by trapped access");
    a_mon_disabled: assert property (monEn_q == 4'h0 |=> (monSts_q & ~$past(monSts_q)) == 4'h0)
        else $error("monitor status set while disabled");
    a_act_clear: assert property (wrAct && regWdata[13] && !(ioCycValid && rangeHit[13]) |=> !actSts_q[13])
        else $error("activity bit not cleared by write one");
    a_act_hold: assert property (actSts_q[10] && !(wrAct && regWdata[10]) |=> actSts_q[10])
        else $error("activity bit dropped without write one");
    a_act_set: assert property (ioCycValid && rangeHit[12] |=> actSts_q[12])
        else $error("activity bit not set by range access");
    a_irq_pair: assert property (irqIf.lineActive[7] |=> actSts_q[9])
        else $error("irq pair activity not recorded");
    a_trap_rsvd: assert property ((trapEn_q & ~`TRAP_VALID_MASK) == 16'h0000)
        else $error("reserved trap enable bit set");
    a_ide_block: assert property (ioCycValid && |(rangeHit & trapEn_q & `IDE_RANGE_MASK) |=> ideForwardBlock)
        else $error("trapped ide cycle not blocked");
    a_addr_cap: assert property ($rose(smi_q) |-> addrCap_q == $past(lastAddr_q))
        else $error("address capture wrong on interrupt rise");
    a_cyc_cap: assert property ($rose(smi_q) |-> cycCap_q == {$past(lastBe_q), $past(lastType_q)})
        else $error("cycle capture wrong on interrupt rise");
    a_summary_or: assert property (actSts_q[5] && trapEn_q[5] |=> monitorSummaryStatus)
        else $error("summary missing enabled status");
    a_gbl_gate: assert property (!globalMgmtIrqEnable |=> !systemMgmtInterrupt)
        else $error("interrupt raised with global enable clear");
    a_set_wins: assert property (ioCycValid && rangeHit[0] && wrAct && regWdata[0] |=> actSts_q[0])
        else $error("set lost to same cycle clear");
endmodule

/* verilog/irq_line_sync.sv */
`timescale 1ns/10ps
`include "trap_mon_map.svh"
module irq_line_sync
    import trap_mon_pkg::*;
#(
    parameter int LINES = 8
)
(
    input  wire logic             clk,
    input  wire logic             rstn,
    input  wire logic [LINES-1:0] pciIrqN,
    irq_sync_if.producer          sync
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!rstn);

    // one synchroniser per irq line
    for (genvar i = 0; i < LINES; i++)
    begin : g_line
        logic [`SYNC_STAGES-1:0] stage_q;  // stage 0 is the metastable catcher
        logic [`SYNC_STAGES-1:0] stage_d;
        logic                    level_q;  // accepted level, active high
        logic                    level_d;

        // shift in the inverted pin; accept a change only when stages 1 and 2 agree
        always_comb
        begin
            stage_d = {stage_q[`SYNC_STAGES-2:0], ~pciIrqN[i]};
            level_d = level_q;
            if (stage_q[1] == stage_q[2])
            begin
                level_d = stage_q[1];
            end
        end

        // register the chain
        always_ff @(posedge clk or negedge rstn)
        begin
            if (!rstn)
            begin
                stage_q <= '0;
                level_q <= 1'b0;
            end
            else
            begin
                stage_q <= stage_d;
                level_q <= level_d;
            end
        end

        assign sync.lineActive[i] = level_q;

        a_sync_agree: assert property ($changed(level_q) |-> $past(stage_q[1] == stage_q[2]))
            else $error("irq level changed without stage agreement");
    end
endmodule
